// ### vss_pkg.sv
// vss_pkg: constants, field layouts, states and carriers of the voltage scan sequencer.
// assumes a 100 MHz system clock; voltages are signed counts of the output DAC.
package vss_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned V_W = 24;
  localparam int unsigned DUR_W = 16;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned NKEY = 9;
  localparam int unsigned NRANGE = 3;
  // long press that arms a scan
  localparam int unsigned ARM_HOLD_MS = 2000;
  localparam int unsigned ARM_HOLD_CYC = ARM_HOLD_MS * (CLK_HZ / 1000);
  // how long the ready message stays up before the begin voltage is shown
  localparam int unsigned READY_MS = 500;
  localparam int unsigned READY_CYC = READY_MS * (CLK_HZ / 1000);
  // ramp update rate
  localparam int unsigned TICK_HZ = 1000;
  localparam int unsigned TICK_CYC = CLK_HZ / TICK_HZ;

  localparam logic [ADDR_W-1:0] A_SETP = 8'h00;
  localparam logic [ADDR_W-1:0] A_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] A_OUTV = 8'h08;
  localparam logic [ADDR_W-1:0] A_BEGV = 8'h0C;
  localparam logic [ADDR_W-1:0] A_ENDV = 8'h10;
  localparam logic [ADDR_W-1:0] A_DURS = 8'h14;
  localparam logic [ADDR_W-1:0] A_SCFG = 8'h18;

  localparam logic [V_W-1:0] V_ZERO = 24'h000000;
  localparam logic [DUR_W-1:0] DUR_RST = 16'h000A;
  localparam logic [1:0] RANGE_RST = 2'h0;
  localparam logic [1:0] RANGE_MAX = 2'h2;

  typedef enum logic [2:0] {P_RANGE, P_BEGIN, P_END, P_DUR, P_SHAPE, P_REPEAT, P_DISP} vss_param_t;
  typedef enum logic [2:0] {M_NORMAL, M_SETUP, M_READY, M_ARMED, M_RUN} vss_mode_t;
  typedef enum logic [1:0] {R_IDLE, R_MUL, R_DIV, R_LOAD} vss_ramp_t;
  typedef enum logic [3:0] {T_NONE, T_RANGE, T_BEGIN, T_END, T_DUR, T_SHAPE, T_REPEAT, T_DISP, T_READY} vss_tag_t;

  typedef struct packed {
    logic sense;
    logic iso;
    logic arm;
    logic right;
    logic left;
    logic up;
    logic down;
    logic cancel;
    logic confirm;
  } vss_keys_t;

  typedef struct packed {
    logic remote_sense;
    logic sense_active;
    logic fault;
    logic scan_armed;
    logic entry_waiting;
  } vss_lamps_t;
endpackage

// ### vss_seq.sv
// vss_seq: output configuration, front-panel scan setup menu and timed linear ramp of the setpoint.
// assumes raw key and short-detect levels from the panel (asynchronous) and a numeric entry
// value from the digit-entry logic on sys_clk; software uses the plain register port.
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module vss_seq
  import vss_pkg::*;
#(
  parameter int unsigned HOLD_CYC = ARM_HOLD_CYC,
  parameter int unsigned RDY_CYC = READY_CYC,
  parameter int unsigned TK_CYC = TICK_CYC,
  parameter int unsigned TK_HZ = TICK_HZ
) (
  input wire logic sys_clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  input wire vss_keys_t keys_i, // raw panel keys, high while pressed
  input wire logic short_i, // raw output short detector
  input wire logic [V_W-1:0] entry_value, // numeric entry value, same clock
  input wire logic [ADDR_W-1:0] addr, // register address
  input wire logic [31:0] wdata, // register write data
  input wire logic wr_stb, // register write strobe
  input wire logic rd_stb, // register read strobe
  output logic [31:0] rdata, // read data, cycle after rd_stb
  output vss_lamps_t lamps, // indicator lamps
  output logic remote_sense, // sense loop at sense terminals
  output logic ground_connect, // low terminal tied to chassis
  output logic [V_W-1:0] setpoint, // output setpoint to the DAC
  output logic [V_W-1:0] disp_value, // numeric display value
  output vss_tag_t disp_tag, // display prefix or message
  output logic scan_busy // scan is running
);
  localparam int unsigned P_W = 32;
  localparam int unsigned PR_W = V_W + 1 + P_W;
  localparam int unsigned NPIN = NKEY + 1;
  localparam int unsigned DC_W = $clog2(PR_W + 1);

  // pin synchronisers: three flops, a level is taken once the second and third agree
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1_r, s2_r, s3_r, stab_r, hit_r;
  assign pin_raw = {keys_i, short_i};
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_sync
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          s1_r[g] <= 1'b0;
          s2_r[g] <= 1'b0;
          s3_r[g] <= 1'b0;
          stab_r[g] <= 1'b0;
          hit_r[g] <= 1'b0;
        end else if (ce) begin
          s1_r[g] <= pin_raw[g];
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
          if (s2_r[g] == s3_r[g])
            stab_r[g] <= s3_r[g];
          hit_r[g] <= (s2_r[g] == s3_r[g]) && s3_r[g] && !stab_r[g];
        end
      end
    end
  endgenerate

  vss_keys_t kp, kl;
  assign kp = vss_keys_t'(hit_r[NPIN-1:1]);
  assign kl = vss_keys_t'(stab_r[NPIN-1:1]);

  // configuration and scan parameters
  logic remote_r, ground_r, shape_r, repeat_r, disp_on_r;
  logic [1:0] range_r;
  logic [V_W-1:0] begv_r, endv_r, setp_r, out_r, dval_r;
  logic [DUR_W-1:0] dur_r;
  vss_mode_t mode_r;
  vss_param_t par_r;
  vss_tag_t tag_r;
  logic [31:0] hold_r, rdy_r;
  logic armed_long_r;

  wire in_setup = (mode_r == M_SETUP);
  wire updn = kp.up | kp.down;
  wire range_chg = in_setup && (par_r == P_RANGE) && updn;
  wire commit = in_setup && kp.confirm;
  wire long_hit = kl.arm && !armed_long_r && (hold_r == HOLD_CYC - 1);
  wire brief_rel = !kl.arm && (hold_r != '0) && !armed_long_r;
  wire bus_wr_setp = wr_stb && (addr == A_SETP);

  wire [1:0] range_up = (range_r == RANGE_MAX) ? RANGE_RST : range_r + 2'h1;
  wire [1:0] range_dn = (range_r == RANGE_RST) ? RANGE_MAX : range_r - 2'h1;
  wire vss_param_t par_fwd = (par_r == P_DISP) ? P_RANGE : vss_param_t'(par_r + 3'h1);
  wire vss_param_t par_bwd = (par_r == P_RANGE) ? P_DISP : vss_param_t'(par_r - 3'h1);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      remote_r <= 1'b0;
      ground_r <= 1'b0;
    end else if (ce) begin
      if (kp.sense)
        remote_r <= !remote_r;
      if (kp.iso)
        ground_r <= !ground_r;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      range_r <= RANGE_RST;
      begv_r <= V_ZERO;
      endv_r <= V_ZERO;
      dur_r <= DUR_RST;
      shape_r <= 1'b0;
      repeat_r <= 1'b0;
      disp_on_r <= 1'b1;
    end else if (ce && in_setup) begin
      if (range_chg) begin
        range_r <= kp.up ? range_up : range_dn;
        begv_r <= V_ZERO;
        endv_r <= V_ZERO;
      end
      if (commit && par_r == P_BEGIN)
        begv_r <= entry_value;
      if (commit && par_r == P_END)
        endv_r <= entry_value;
      if (commit && par_r == P_DUR)
        dur_r <= entry_value[DUR_W-1:0];
      if (updn && par_r == P_SHAPE)
        shape_r <= !shape_r;
      if (updn && par_r == P_REPEAT)
        repeat_r <= !repeat_r;
      if (updn && par_r == P_DISP)
        disp_on_r <= !disp_on_r;
    end
  end

  // arm key timing: a release before the hold time is a brief press
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hold_r <= '0;
      armed_long_r <= 1'b0;
    end else if (ce) begin
      if (!kl.arm) begin
        hold_r <= '0;
        armed_long_r <= 1'b0;
      end else if (long_hit) begin
        armed_long_r <= 1'b1;
      end else if (!armed_long_r) begin
        hold_r <= hold_r + 32'h1;
      end
    end
  end

  // ramp engine
  logic [P_W-1:0] nh_r, n_r, pos_r;
  logic [31:0] tick_r;
  logic down_half_r;
  logic [PR_W-1:0] quo_r;
  logic [P_W:0] rem_r;
  logic [DC_W-1:0] dcnt_r;
  logic span_neg_r;
  logic [V_W:0] span_mag_r;
  vss_ramp_t rs_r;

  wire [V_W:0] span = {endv_r[V_W-1], endv_r} - {begv_r[V_W-1], begv_r};
  wire [P_W-1:0] n_total = P_W'(dur_r) * P_W'(TK_HZ);
  // a two-way scan halves the tick budget so both legs are the same length
  wire [P_W-1:0] nh_start = shape_r ? (n_total >> 1) : n_total;
  wire tick = (tick_r == TK_CYC - 1);
  wire [P_W:0] rem_sh = {rem_r[P_W-1:0], quo_r[PR_W-1]};
  wire rem_ge = rem_sh >= {1'b0, nh_r};
  wire [V_W:0] q_lo = quo_r[V_W:0];
  wire [V_W:0] ramp_sum = {begv_r[V_W-1], begv_r} + (span_neg_r ? -q_lo : q_lo);
  // an empty leg ends on its first load, since the tick count can never meet a zero leg length
  wire last_tick = (nh_r == '0) || ((n_r == nh_r) && (!shape_r || down_half_r));
  wire start_run = (mode_r == M_ARMED) && kp.confirm;
  wire ramp_done = (rs_r == R_LOAD) && last_tick;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rs_r <= R_IDLE;
      tick_r <= '0;
      n_r <= '0;
      nh_r <= '0;
      pos_r <= '0;
      down_half_r <= 1'b0;
      quo_r <= '0;
      rem_r <= '0;
      dcnt_r <= '0;
      span_neg_r <= 1'b0;
      span_mag_r <= '0;
    end else if (ce) begin
      if (mode_r != M_RUN || start_run) begin
        tick_r <= '0;
        n_r <= '0;
        down_half_r <= 1'b0;
        nh_r <= nh_start;
        span_neg_r <= span[V_W];
        span_mag_r <= span[V_W] ? -span : span;
        rs_r <= R_IDLE;
      end else begin
        tick_r <= tick ? '0 : tick_r + 32'h1;
        unique case (rs_r)
          R_IDLE: if (tick) begin
            // position within the current leg; the down leg counts back toward begin
            pos_r <= down_half_r ? nh_r - n_r - 32'h1 : n_r + 32'h1;
            n_r <= n_r + 32'h1;
            rs_r <= R_MUL;
          end
          R_MUL: begin
            quo_r <= PR_W'(span_mag_r) * PR_W'(pos_r);
            rem_r <= '0;
            dcnt_r <= DC_W'(PR_W);
            rs_r <= (nh_r == '0) ? R_LOAD : R_DIV;
          end
          R_DIV: begin
            // restoring divide by the leg length, one quotient bit a cycle
            rem_r <= rem_ge ? rem_sh - {1'b0, nh_r} : rem_sh;
            quo_r <= {quo_r[PR_W-2:0], rem_ge};
            dcnt_r <= dcnt_r - 1'b1;
            if (dcnt_r == 1)
              rs_r <= R_LOAD;
          end
          R_LOAD: begin
            rs_r <= R_IDLE;
            if (n_r == nh_r && shape_r && !down_half_r) begin
              down_half_r <= 1'b1;
              n_r <= '0;
            end else if (last_tick) begin
              n_r <= '0;
              down_half_r <= 1'b0;
            end
          end
          default: rs_r <= R_IDLE;
        endcase
      end
    end
  end

  // setpoint value the ramp loads this cycle; an empty duration jumps straight to the end, or to begin in a two-way scan
  wire [V_W-1:0] ramp_val = (nh_r == '0) ? (shape_r ? begv_r : endv_r) : ramp_sum[V_W-1:0];
  wire ramp_load = (mode_r == M_RUN) && (rs_r == R_LOAD);

  // operating mode, menu position and ready timer
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mode_r <= M_NORMAL;
      par_r <= P_RANGE;
      rdy_r <= '0;
    end else if (ce) begin
      if (kp.right && in_setup)
        par_r <= par_fwd;
      if (kp.left && in_setup)
        par_r <= par_bwd;
      if (long_hit && mode_r != M_RUN) begin
        mode_r <= M_READY;
        rdy_r <= '0;
      end else begin
        unique case (mode_r)
          M_NORMAL: if (brief_rel) begin
            mode_r <= M_SETUP;
            par_r <= P_RANGE;
          end
          M_SETUP: if (kp.cancel)
            mode_r <= M_NORMAL;
          M_READY: begin
            rdy_r <= rdy_r + 32'h1;
            if (rdy_r == RDY_CYC - 1)
              mode_r <= M_ARMED;
          end
          M_ARMED: if (kp.cancel)
            mode_r <= M_NORMAL;
          else if (start_run)
            mode_r <= M_RUN;
          M_RUN: if (kp.cancel || (ramp_done && !repeat_r))
            mode_r <= M_NORMAL;
          default: mode_r <= M_NORMAL;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      setp_r <= V_ZERO;
      out_r <= V_ZERO;
    end else if (ce) begin
      if (bus_wr_setp)
        setp_r <= wdata[V_W-1:0];
      if (ramp_load)
        out_r <= ramp_val;
      else if (bus_wr_setp && mode_r != M_RUN)
        out_r <= wdata[V_W-1:0];
    end
  end

  // display selection; a frozen display keeps its last value through the scan
  vss_tag_t tag_nxt;
  logic [V_W-1:0] dval_nxt;
  always_comb begin
    tag_nxt = T_NONE;
    dval_nxt = dval_r;
    unique case (mode_r)
      M_SETUP: begin
        unique case (par_r)
          P_RANGE: begin
            tag_nxt = T_RANGE;
            dval_nxt = V_W'(range_r);
          end
          P_BEGIN: begin
            tag_nxt = T_BEGIN;
            dval_nxt = begv_r;
          end
          P_END: begin
            tag_nxt = T_END;
            dval_nxt = endv_r;
          end
          P_DUR: begin
            tag_nxt = T_DUR;
            dval_nxt = V_W'(dur_r);
          end
          P_SHAPE: begin
            tag_nxt = T_SHAPE;
            dval_nxt = V_W'(shape_r);
          end
          P_REPEAT: begin
            tag_nxt = T_REPEAT;
            dval_nxt = V_W'(repeat_r);
          end
          P_DISP: begin
            tag_nxt = T_DISP;
            dval_nxt = V_W'(disp_on_r);
          end
          default: tag_nxt = T_NONE;
        endcase
      end
      M_READY: tag_nxt = T_READY;
      M_ARMED: dval_nxt = begv_r;
      M_RUN: dval_nxt = (disp_on_r && ramp_load) ? ramp_val : dval_r;
      M_NORMAL: dval_nxt = ramp_load ? ramp_val : out_r;
      default: tag_nxt = T_NONE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tag_r <= T_NONE;
      dval_r <= V_ZERO;
    end else if (ce) begin
      tag_r <= tag_nxt;
      dval_r <= dval_nxt;
    end
  end

  // register read port
  logic [31:0] rd_mux, rdata_r;
  wire [31:0] stat_w = {20'h00000, 1'b0, mode_r, par_r, 1'b0, stab_r[0], ground_r, remote_r};
  always_comb begin
    unique case (addr)
      A_SETP: rd_mux = {{(32-V_W){setp_r[V_W-1]}}, setp_r};
      A_STAT: rd_mux = stat_w;
      A_OUTV: rd_mux = {{(32-V_W){out_r[V_W-1]}}, out_r};
      A_BEGV: rd_mux = {{(32-V_W){begv_r[V_W-1]}}, begv_r};
      A_ENDV: rd_mux = {{(32-V_W){endv_r[V_W-1]}}, endv_r};
      A_DURS: rd_mux = {16'h0000, dur_r};
      A_SCFG: rd_mux = {27'h0000000, disp_on_r, repeat_r, shape_r, range_r};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
      rdata_r <= 32'h00000000;
    else if (ce)
      rdata_r <= rd_stb ? rd_mux : 32'h00000000;
  end

  assign rdata = rdata_r;
  assign remote_sense = remote_r;
  assign ground_connect = ground_r;
  assign lamps.remote_sense = remote_r;
  assign lamps.sense_active = remote_r;
  assign lamps.fault = stab_r[0];
  assign lamps.scan_armed = (mode_r == M_READY) || (mode_r == M_ARMED);
  assign lamps.entry_waiting = (mode_r == M_ARMED);
  assign setpoint = out_r;
  assign disp_value = dval_r;
  assign disp_tag = tag_r;
  assign scan_busy = (mode_r == M_RUN);
endmodule
`default_nettype wire

// ### vss_seq_checker.sv
// vss_seq_checker: port-level assertions for the voltage scan sequencer.
// assumes it is bound onto vss_seq and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module vss_seq_checker
  import vss_pkg::*;
(
  input wire logic sys_clk, // clock
  input wire logic nrst, // reset, active low
  input wire logic ce, // clock enable
  input wire vss_keys_t keys_i, // keys
  input wire logic short_i, // short detector
  input wire logic [ADDR_W-1:0] addr, // address
  input wire logic wr_stb, // write strobe
  input wire logic rd_stb, // read strobe
  input wire logic [31:0] rdata, // read data
  input wire vss_lamps_t lamps, // lamps
  input wire logic remote_sense, // remote sensing
  input wire logic ground_connect, // grounded
  input wire logic [V_W-1:0] setpoint, // setpoint
  input wire vss_tag_t disp_tag, // display tag
  input wire logic scan_busy // running
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_sense_lamps: assert property (lamps.remote_sense == remote_sense && lamps.sense_active == remote_sense)
    else $error("sense lamps disagree");
  a_sense_cause: assert property ($changed(remote_sense) |-> $past(keys_i.sense, 3) || $past(keys_i.sense, 5))
    else $error("sensing changed without key");
  a_ground_cause: assert property ($changed(ground_connect) |-> $past(keys_i.iso, 3) || $past(keys_i.iso, 5))
    else $error("reference changed without key");
  a_fault_on: assert property ((ce && short_i) [*6] |-> lamps.fault)
    else $error("fault lamp dark while shorted");
  a_fault_off: assert property ((ce && !short_i) [*6] |-> !lamps.fault)
    else $error("fault lamp lit without short");
  a_setp_hold: assert property (!scan_busy && !$past(scan_busy) && !$past(scan_busy, 2) && !$past(wr_stb)
    |-> $stable(setpoint))
    else $error("setpoint moved while idle");
  a_start_armed: assert property ($rose(scan_busy) |-> $past(lamps.entry_waiting))
    else $error("scan started unarmed");
  a_wait_armed: assert property (lamps.entry_waiting |-> lamps.scan_armed && !scan_busy)
    else $error("waiting lamp without armed lamp");
  a_ready_tag: assert property ($rose(lamps.scan_armed) |-> ##[0:1] disp_tag == T_READY)
    else $error("no ready message on arming");
  a_outv_read: assert property (rd_stb && addr == A_OUTV |=> rdata[V_W-1:0] == $past(setpoint)
    && rdata[31:V_W] == {8{rdata[V_W-1]}})
    else $error("setpoint readback wrong");
  a_rdata_idle: assert property (!rd_stb |=> rdata == 32'h0)
    else $error("read data outside read cycle");
endmodule
bind vss_seq vss_seq_checker vss_seq_checker_inst (.sys_clk(sys_clk), .nrst(nrst), .ce(ce), .keys_i(keys_i),
  .short_i(short_i), .addr(addr), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .lamps(lamps),
  .remote_sense(remote_sense), .ground_connect(ground_connect), .setpoint(setpoint), .disp_tag(disp_tag),
  .scan_busy(scan_busy));
`default_nettype wire

// ### vss_panel.sv
// vss_panel: front-panel operator model, keys and numeric entry value.
// assumes the sequencer synchronises the keys itself on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module vss_panel
  import vss_pkg::*;
(
  input wire logic sys_clk, // clock
  output vss_keys_t keys, // key levels, high while pressed
  output logic [V_W-1:0] entry // numeric entry value
);
  initial begin
    keys = '0;
    entry = V_ZERO;
  end
  // the release gap lets the synchronisers settle low before the next press
  task automatic press(input int idx, input int hold);
    @(posedge sys_clk);
    keys[idx] <= 1'b1;
    repeat (hold) @(posedge sys_clk);
    keys[idx] <= 1'b0;
    repeat (12) @(posedge sys_clk);
  endtask
  task automatic set_entry(input logic [V_W-1:0] v);
    @(posedge sys_clk);
    entry <= v;
  endtask
endmodule
`default_nettype wire

// ### test_voltage_scan_sequencer.sv
// test_voltage_scan_sequencer: self-checking bench for vss_seq with the panel model.
// assumes shortened hold, ready and tick counts so a scan lasts a few hundred cycles.
`timescale 1ns/1ps
`default_nettype none
module test_voltage_scan_sequencer
  import vss_pkg::*;
;
  localparam int K_SENSE = 8, K_ISO = 7, K_ARM = 6, K_RIGHT = 5, K_LEFT = 4;
  localparam int K_UP = 3, K_DOWN = 2, K_CANCEL = 1, K_OK = 0, HOLD = 40;
  localparam logic [V_W-1:0] BEG = 24'h000100, FIN = 24'h001000, MID = 24'h000880;
  typedef struct packed {logic [3:0] k; logic rs; logic gc;} vss_row_t;
  vss_row_t rows [4] = '{'{4'h8, 1'b1, 1'b0}, '{4'h7, 1'b1, 1'b1}, '{4'h8, 1'b0, 1'b1}, '{4'h7, 1'b0, 1'b0}};
  logic sys_clk = 1'b0, nrst = 1'b0, short_i = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  vss_keys_t keys;
  vss_lamps_t lamps;
  vss_tag_t disp_tag;
  logic [V_W-1:0] entry, setpoint, disp_value, last_v, prev_v;
  logic remote_sense, ground_connect, scan_busy;
  int fails = 0, checks = 0;
  always #5 sys_clk = ~sys_clk;
  vss_panel vss_panel_inst (.sys_clk(sys_clk), .keys(keys), .entry(entry));
  vss_seq #(.HOLD_CYC(HOLD), .RDY_CYC(10), .TK_CYC(100), .TK_HZ(2)) vss_seq_inst (.sys_clk(sys_clk),
    .nrst(nrst), .ce(1'b1), .keys_i(keys), .short_i(short_i), .entry_value(entry), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .lamps(lamps),
    .remote_sense(remote_sense), .ground_connect(ground_connect), .setpoint(setpoint),
    .disp_value(disp_value), .disp_tag(disp_tag), .scan_busy(scan_busy));
  task automatic test_done;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t output %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bus(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1;
    checks++;
    if (rdata !== exp) begin
      fails++;
      $display("BAD %0t read %h gave %h expected %h", $time, a, rdata, exp);
    end
  endtask
  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic enter(input int k, input logic [V_W-1:0] v);
    vss_panel_inst.press(k, 8);
    vss_panel_inst.set_entry(v);
    vss_panel_inst.press(K_OK, 8);
  endtask
  // records the last two distinct setpoints seen while and shortly after the scan runs
  task automatic run_scan(input logic [V_W-1:0] exp_prev, input logic [V_W-1:0] exp_last, input logic live);
    int n;
    int bad;
    bad = 0;
    vss_panel_inst.press(K_ARM, HOLD + 20);
    chk_out(lamps.entry_waiting, 1'b1);
    chk_out(disp_value, BEG);
    vss_panel_inst.press(K_OK, 8);
    chk_out(scan_busy, 1'b1);
    prev_v = setpoint;
    last_v = setpoint;
    for (n = 0; n < 450; n++) begin
      @(negedge sys_clk);
      if (setpoint !== last_v) begin
        prev_v = last_v;
        last_v = setpoint;
        // a live display follows every load, a frozen one keeps the begin voltage shown on arming
        if (disp_value !== (live ? setpoint : BEG))
          bad++;
      end
    end
    chk_out(bad, 0);
    chk_out(scan_busy, 1'b0);
    chk_out(prev_v, exp_prev);
    chk_out(last_v, exp_last);
    $display("done: scan to %h", exp_last);
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    test_done;
  end
  initial begin
    int i;
    repeat (8) @(posedge sys_clk);
    chk_out({setpoint, lamps, remote_sense, ground_connect, scan_busy}, 32'h0);
    chk_out(disp_tag, T_NONE);
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    chk_bus(A_DURS, 32'h0000000A);
    chk_bus(A_SCFG, 32'h00000010);
    chk_bus(8'h1C, 32'h0);
    reg_wr(A_SETP, 32'h00FFFFFF);
    chk_bus(A_OUTV, 32'hFFFFFFFF);
    $display("done: reset and registers");
    for (i = 0; i < 4; i++) begin
      vss_panel_inst.press(rows[i].k, 12);
      chk_out(remote_sense, rows[i].rs);
      chk_out(lamps.sense_active, rows[i].rs);
      chk_out(ground_connect, rows[i].gc);
    end
    short_i <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk_out(lamps.fault, 1'b1);
    short_i <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk_out(lamps.fault, 1'b0);
    $display("done: configuration");
    vss_panel_inst.press(K_ARM, 8);
    chk_out(disp_tag, T_RANGE);
    for (i = 1; i <= 7; i++) begin
      vss_panel_inst.press(K_RIGHT, 8);
      chk_out(disp_tag, 32'(1 + i % 7));
    end
    vss_panel_inst.press(K_LEFT, 8);
    chk_out(disp_tag, T_DISP);
    vss_panel_inst.press(K_RIGHT, 8);
    enter(K_RIGHT, BEG);
    chk_out(disp_tag, T_BEGIN);
    chk_bus(A_BEGV, {8'h00, BEG});
    enter(K_RIGHT, FIN);
    chk_bus(A_ENDV, {8'h00, FIN});
    vss_panel_inst.press(K_LEFT, 8);
    vss_panel_inst.press(K_LEFT, 8);
    vss_panel_inst.press(K_UP, 8);
    chk_bus(A_SCFG, 32'h00000011);
    chk_bus(A_BEGV, 32'h0);
    chk_bus(A_ENDV, 32'h0);
    vss_panel_inst.press(K_DOWN, 8);
    enter(K_RIGHT, BEG);
    enter(K_RIGHT, FIN);
    enter(K_RIGHT, 24'h000001);
    chk_bus(A_DURS, 32'h00000001);
    for (i = 2; i <= 4; i++) begin
      vss_panel_inst.press(K_RIGHT, 8);
      vss_panel_inst.press(K_UP, 8);
      chk_bus(A_SCFG, (32'h1 << i) ^ 32'h10);
      vss_panel_inst.press(K_DOWN, 8);
      chk_bus(A_SCFG, 32'h00000010);
    end
    vss_panel_inst.press(K_CANCEL, 8);
    chk_out(disp_tag, T_NONE);
    chk_bus(A_BEGV, {8'h00, BEG});
    $display("done: setup menu");
    run_scan(MID, FIN, 1'b1);
    vss_panel_inst.press(K_ARM, 8);
    chk_out(disp_tag, T_RANGE);
    vss_panel_inst.press(K_LEFT, 8);
    vss_panel_inst.press(K_UP, 8);
    for (i = 0; i < 2; i++) begin
      vss_panel_inst.press(K_LEFT, 8);
    end
    vss_panel_inst.press(K_UP, 8);
    chk_bus(A_SCFG, 32'h00000004);
    vss_panel_inst.press(K_CANCEL, 8);
    // move the output off the end voltage so the up leg of the next scan shows as a change
    reg_wr(A_SETP, 32'h00000000);
    run_scan(FIN, BEG, 1'b0);
    test_done;
  end
endmodule
`default_nettype wire
